// ### rtl/rtc_defines.vh
// Constants for the calendar clock with shadow access
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define OFS_TRIM 16'h2504
`define OFS_CTRL 16'h2890
`define OFS_RESTART 16'h2891
`define OFS_FRACTION_SECOND_COUNTER 16'h2892
`define OFS_SEC 16'h2893
`define OFS_MIN 16'h2894
`define OFS_HOUR 16'h2895
`define OFS_DOW 16'h2896
`define OFS_DAY 16'h2897
`define OFS_MONTH 16'h2898
`define OFS_YEAR 16'h2899
`define OFS_P_HIGH 16'h289b
`define OFS_P_MID 16'h289c
`define OFS_P_LOW 16'h289d

// ****************************************
// Field positions
// ****************************************
`define CTRL_WR_BIT 7
`define CTRL_RD_BIT 6
`define CTRL_FAIL_BIT 4
`define RESTART_BIT 0

// ****************************************
// Reset values
// ****************************************
`define TRIM_RST 7'h40
`define SEC_RST 8'h00
`define MIN_RST 8'h00
`define HOUR_RST 8'h00
`define DOW_RST 8'h01
`define DAY_RST 8'h01
`define MONTH_RST 8'h01
`define YEAR_RST 8'h00
`define P_HIGH_RST 8'h04
`define P_MID_RST 8'h00
`define P_LOW_RST 8'h00
`define PQ_RST 19'h40000

// ****************************************
// Timing
// ****************************************
`define REF_CLK_HZ 24'h989680
`define XTAL_HZ 24'h008000
`define TICK_DIV_LAST 6'h3f
`define FRACTION_SECOND_COUNTER_DIV_LAST 8'hff
`define FRACTION_SECOND_COUNTER_MAX 8'h7f
`define WORDS 10

`endif

// ### rtl/date_advance.v
// Next-second calendar value and validity check
`timescale 1ns/10ps
`default_nettype none

module date_advance (
  // Present calendar words
  input wire [7:0] sec_i,
  input wire [7:0] min_i,
  input wire [7:0] hour_i,
  input wire [7:0] dow_i,
  input wire [7:0] day_i,
  input wire [7:0] month_i,
  input wire [7:0] year_i,
  // Calendar one second later
  output reg [7:0] sec_o,
  output reg [7:0] min_o,
  output reg [7:0] hour_o,
  output reg [7:0] dow_o,
  output reg [7:0] day_o,
  output reg [7:0] month_o,
  output reg [7:0] year_o,
  // Chain holds an impossible value
  output reg bad_o
);

  reg [7:0] mlen; // Days in current month

  // ****************************************
  // Month length, leap aware
  // ****************************************
  always @* begin
    case (month_i)
      8'h02: mlen = (year_i[1:0] == 2'h0) ? 8'h1d : 8'h1c;
      8'h04, 8'h06, 8'h09, 8'h0b: mlen = 8'h1e;
      default: mlen = 8'h1f;
    endcase
  end

  // ****************************************
  // Carry ripple through the chain
  // ****************************************
  always @* begin
    sec_o = sec_i;
    min_o = min_i;
    hour_o = hour_i;
    dow_o = dow_i;
    day_o = day_i;
    month_o = month_i;
    year_o = year_i;
    if (sec_i >= 8'h3b) begin
      sec_o = 8'h00;
      if (min_i >= 8'h3b) begin
        min_o = 8'h00;
        if (hour_i >= 8'h17) begin
          hour_o = 8'h00;
          dow_o = (dow_i >= 8'h07) ? 8'h01 : dow_i + 8'h01;
          if (day_i >= mlen) begin
            day_o = 8'h01;
            if (month_i >= 8'h0c) begin
              month_o = 8'h01;
              year_o = year_i + 8'h01;
            end else begin
              month_o = month_i + 8'h01;
            end
          end else begin
            day_o = day_i + 8'h01;
          end
        end else begin
          hour_o = hour_i + 8'h01;
        end
      end else begin
        min_o = min_i + 8'h01;
      end
    end else begin
      sec_o = sec_i + 8'h01;
    end
  end

  // ****************************************
  // Range check of every word except the year
  // ****************************************
  always @* begin
    bad_o = (sec_i > 8'h3b) || (min_i > 8'h3b) || (hour_i > 8'h17) ||
            (dow_i == 8'h00) || (dow_i > 8'h07) || (day_i == 8'h00) ||
            (day_i > mlen) || (month_i == 8'h00) || (month_i > 8'h0c);
  end

endmodule

`default_nettype wire

// ### rtl/calendar_rtc.v
// Calendar clock with frozen shadow access over the byte register port
`timescale 1ns/10ps
`default_nettype none
`include "rtc_defines.vh"

// Contract
// - Seven calendar counters behind a shared shadow
// - Chain advances on crystal ticks only
// - Shadow refreshes each internal tick when unfrozen
// - Read freeze holds shadow constant
// - Read freeze reads one until refreshed
// - Write freeze halts refresh, accepts writes
// - Unfreeze write loads chain next tick
// - Change flags select words to load
// - Write freeze reads one until loaded
// - Read-only subsecond count in 1/128 s
// - Restart bit zeroes subsecond counter
// - February gains a day in leap years
// - Chain ignores reset, watchdog and sleep
// - Count error flag, cleared by writing zero
// - Rate values via shadow, next second
// - Period 0x40000 gives 32768 ticks per second
module calendar_rtc #(
  // Reference clock rate in hertz
  parameter [23:0] REF_HZ = `REF_CLK_HZ
) (
  // Clock and resets
  input wire ref_clk,
  input wire rst,
  input wire por,
  // Byte register port
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  // Status and analog trim
  output reg [6:0] crystal_load_trim,
  output reg second_pulse
);

  // ****************************************
  // Word table helpers
  // ****************************************
  // Byte address of each shadow word
  function [15:0] word_addr;
    input integer i;
    begin
      case (i)
        0: word_addr = `OFS_SEC;
        1: word_addr = `OFS_MIN;
        2: word_addr = `OFS_HOUR;
        3: word_addr = `OFS_DOW;
        4: word_addr = `OFS_DAY;
        5: word_addr = `OFS_MONTH;
        6: word_addr = `OFS_YEAR;
        7: word_addr = `OFS_P_HIGH;
        8: word_addr = `OFS_P_MID;
        default: word_addr = `OFS_P_LOW;
      endcase
    end
  endfunction

  // Writable bits of each word
  function [7:0] word_mask;
    input integer i;
    begin
      case (i)
        0, 1: word_mask = 8'h3f;
        2, 4: word_mask = 8'h1f;
        3, 7: word_mask = 8'h07;
        5: word_mask = 8'h0f;
        default: word_mask = 8'hff;
      endcase
    end
  endfunction

  // Power-on value of each word
  function [7:0] word_rst;
    input integer i;
    begin
      case (i)
        0: word_rst = `SEC_RST;
        1: word_rst = `MIN_RST;
        2: word_rst = `HOUR_RST;
        3: word_rst = `DOW_RST;
        4: word_rst = `DAY_RST;
        5: word_rst = `MONTH_RST;
        6: word_rst = `YEAR_RST;
        7: word_rst = `P_HIGH_RST;
        8: word_rst = `P_MID_RST;
        default: word_rst = `P_LOW_RST;
      endcase
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [7:0] live_r [0:`WORDS-1]; // Counter chain words
  reg [7:0] shadow_r [0:`WORDS-1]; // Shadow words
  reg [`WORDS-1:0] flag_r; // Change flag per word
  wire [7:0] adv [0:`WORDS-1]; // Chain one second on
  reg [23:0] xacc_r; // Crystal rate accumulator
  reg xtick_r; // Crystal tick enable
  reg [5:0] tdiv_r; // Divider to internal tick
  reg [15:0] tcnt_r; // Crystal ticks this second
  reg [2:0] rem_r; // Eighth-tick remainder
  reg [18:0] pq_r; // Rate in use this second
  reg [7:0] sdiv_r; // Ticks within a subsecond
  reg [7:0] fraction_second_counter_r; // Subsecond count
  reg rd_freeze_r; // Read freeze bit
  reg rd_stale_r; // Awaiting first refresh
  reg wr_freeze_r; // Write freeze bit
  reg wr_pend_r; // Awaiting chain load
  reg fail_r; // Count error flag
  reg [7:0] rdata_nxt; // Read mux result
  wire bad; // Chain out of range
  wire [18:0] pq_live; // Rate held in chain
  wire [18:0] sec_sum; // Rate plus remainder
  wire [15:0] sec_len; // Ticks in this second
  wire sec_edge; // Second boundary
  wire int_tick; // About 500 Hz tick
  wire do_refresh; // Shadow takes chain
  wire do_xfer; // Chain takes flagged words
  wire ctrl_wr; // Write to control byte
  integer k;

  // ****************************************
  // Crystal tick and internal tick
  // ****************************************
  // Fractional divider giving exact 32768 Hz average
  always @(posedge ref_clk) begin
    if (por) begin
      xacc_r <= 24'h000000;
      xtick_r <= 1'b0;
    end else if (xacc_r >= REF_HZ - `XTAL_HZ) begin
      xacc_r <= xacc_r + `XTAL_HZ - REF_HZ;
      xtick_r <= 1'b1;
    end else begin
      xacc_r <= xacc_r + `XTAL_HZ;
      xtick_r <= 1'b0;
    end
  end

  // Divide crystal ticks by 64
  always @(posedge ref_clk) begin
    if (por) begin
      tdiv_r <= 6'h00;
    end else if (xtick_r) begin
      tdiv_r <= tdiv_r + 6'h01;
    end
  end

  assign int_tick = xtick_r && (tdiv_r == `TICK_DIV_LAST);

  // ****************************************
  // Second length with rate correction
  // ****************************************
  assign pq_live = {live_r[7][2:0], live_r[8], live_r[9]};
  assign sec_sum = pq_r + {16'h0000, rem_r};
  assign sec_len = sec_sum[18:3];
  assign sec_edge = xtick_r && (tcnt_r == sec_len - 16'h0001);

  // Tick count, remainder and rate take-up per second
  always @(posedge ref_clk) begin
    if (por) begin
      tcnt_r <= 16'h0000;
      rem_r <= 3'h0;
      pq_r <= `PQ_RST;
    end else if (sec_edge) begin
      tcnt_r <= 16'h0000;
      rem_r <= sec_sum[2:0];
      pq_r <= pq_live;
    end else if (xtick_r) begin
      tcnt_r <= tcnt_r + 16'h0001;
    end
  end

  // ****************************************
  // Subsecond counter
  // ****************************************
  // Counts 1/128 s, zero at boundary or restart
  always @(posedge ref_clk) begin
    if (por) begin
      sdiv_r <= 8'h00;
      fraction_second_counter_r <= 8'h00;
    end else if (io_wr && io_addr == `OFS_RESTART &&
                 io_wdata[`RESTART_BIT]) begin
      sdiv_r <= 8'h00;
      fraction_second_counter_r <= 8'h00;
    end else if (sec_edge) begin
      sdiv_r <= 8'h00;
      fraction_second_counter_r <= 8'h00;
    end else if (xtick_r) begin
      sdiv_r <= sdiv_r + 8'h01;
      if (sdiv_r == `FRACTION_SECOND_COUNTER_DIV_LAST && fraction_second_counter_r != `FRACTION_SECOND_COUNTER_MAX) begin
        fraction_second_counter_r <= fraction_second_counter_r + 8'h01;
      end
    end
  end

  // ****************************************
  // Calendar advance
  // ****************************************
  date_advance u_adv (
    .sec_i(live_r[0]),
    .min_i(live_r[1]),
    .hour_i(live_r[2]),
    .dow_i(live_r[3]),
    .day_i(live_r[4]),
    .month_i(live_r[5]),
    .year_i(live_r[6]),
    .sec_o(adv[0]),
    .min_o(adv[1]),
    .hour_o(adv[2]),
    .dow_o(adv[3]),
    .day_o(adv[4]),
    .month_o(adv[5]),
    .year_o(adv[6]),
    .bad_o(bad)
  );

  // Rate words do not count
  assign adv[7] = live_r[7];
  assign adv[8] = live_r[8];
  assign adv[9] = live_r[9];

  // ****************************************
  // Shadow control
  // ****************************************
  assign ctrl_wr = io_wr && (io_addr == `OFS_CTRL);
  assign do_refresh = int_tick && !rd_freeze_r && !wr_freeze_r &&
                      !wr_pend_r;
  assign do_xfer = int_tick && wr_pend_r && !wr_freeze_r;

  // Freeze bits and their trailing status
  always @(posedge ref_clk) begin
    if (rst) begin
      rd_freeze_r <= 1'b0;
      rd_stale_r <= 1'b0;
      wr_freeze_r <= 1'b0;
      wr_pend_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        rd_freeze_r <= io_wdata[`CTRL_RD_BIT];
        wr_freeze_r <= io_wdata[`CTRL_WR_BIT];
      end
      // Lowering read freeze leaves status high until refresh
      if (ctrl_wr && rd_freeze_r && !io_wdata[`CTRL_RD_BIT]) begin
        rd_stale_r <= 1'b1;
      end else if (do_refresh) begin
        rd_stale_r <= 1'b0;
      end
      // Lowering write freeze arms the chain load
      if (ctrl_wr && wr_freeze_r && !io_wdata[`CTRL_WR_BIT]) begin
        wr_pend_r <= 1'b1;
      end else if (do_xfer) begin
        wr_pend_r <= 1'b0;
      end
    end
  end

  // Count error flag, set beats clear
  always @(posedge ref_clk) begin
    if (rst) begin
      fail_r <= 1'b0;
    end else if (sec_edge && bad) begin
      fail_r <= 1'b1;
    end else if (ctrl_wr && !io_wdata[`CTRL_FAIL_BIT]) begin
      fail_r <= 1'b0;
    end
  end

  // ****************************************
  // Per-word shadow and chain
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < `WORDS; gi = gi + 1) begin : g_word
      // Shadow word and its change flag
      always @(posedge ref_clk) begin
        if (rst) begin
          shadow_r[gi] <= word_rst(gi);
          flag_r[gi] <= 1'b0;
        end else if (io_wr && io_addr == word_addr(gi) && wr_freeze_r) begin
          shadow_r[gi] <= io_wdata & word_mask(gi);
          flag_r[gi] <= 1'b1;
        end else if (do_xfer) begin
          flag_r[gi] <= 1'b0;
        end else if (do_refresh) begin
          shadow_r[gi] <= live_r[gi];
        end
      end

      // Chain word, untouched by the system reset
      always @(posedge ref_clk) begin
        if (por) begin
          live_r[gi] <= word_rst(gi);
        end else if (do_xfer && flag_r[gi]) begin
          live_r[gi] <= shadow_r[gi];
        end else if (sec_edge) begin
          live_r[gi] <= adv[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Register reads
  // ****************************************
  // Read mux, unmapped addresses give zero
  always @* begin
    rdata_nxt = 8'h00;
    if (io_addr == `OFS_CTRL) begin
      rdata_nxt[`CTRL_WR_BIT] = wr_freeze_r | wr_pend_r;
      rdata_nxt[`CTRL_RD_BIT] = rd_freeze_r | rd_stale_r;
      rdata_nxt[`CTRL_FAIL_BIT] = fail_r;
    end else if (io_addr == `OFS_FRACTION_SECOND_COUNTER) begin
      rdata_nxt = fraction_second_counter_r;
    end else if (io_addr == `OFS_TRIM) begin
      rdata_nxt = {1'b0, crystal_load_trim};
    end
    for (k = 0; k < `WORDS; k = k + 1) begin
      if (io_addr == word_addr(k)) begin
        rdata_nxt = shadow_r[k];
      end
    end
  end

  // Registered read data
  always @(posedge ref_clk) begin
    if (rst) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      io_rdata <= rdata_nxt;
    end
  end

  // ****************************************
  // Trim register and second pulse
  // ****************************************
  // Analog load trim, plain storage
  always @(posedge ref_clk) begin
    if (rst) begin
      crystal_load_trim <= `TRIM_RST;
    end else if (io_wr && io_addr == `OFS_TRIM) begin
      crystal_load_trim <= io_wdata[6:0];
    end
  end

  // One-cycle pulse at each second boundary
  always @(posedge ref_clk) begin
    if (por) begin
      second_pulse <= 1'b0;
    end else begin
      second_pulse <= sec_edge;
    end
  end

endmodule

`default_nettype wire

// ### test/calendar_rtc_assertions.sv
// Port-level checks for the calendar clock
`timescale 1ns/10ps
`default_nettype none
`include "rtc_defines.vh"

// ****************************************
// Checker
// ****************************************
module calendar_rtc_chk (
  // Clock and resets
  input wire ref_clk,
  input wire rst,
  input wire por,
  // Register port
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  // Status
  input wire [6:0] crystal_load_trim,
  input wire second_pulse
);
  // Decoded accesses
  wire wr_trim = io_wr && io_addr == `OFS_TRIM;
  wire rd_trim = io_rd && io_addr == `OFS_TRIM;
  wire rd_none = io_rd && io_addr == 16'h2000;
  wire wr_rs = io_wr && io_addr == `OFS_RESTART && io_wdata[0];
  wire rd_sub = io_rd && io_addr == `OFS_FRACTION_SECOND_COUNTER;
  wire wr_ctl = io_wr && io_addr == `OFS_CTRL;
  wire rd_ctl = io_rd && io_addr == `OFS_CTRL;
  // Freeze bits of the write data
  wire [1:0] wfrz = io_wdata[7:6];

  a_reset_values: assert property (@(posedge ref_clk) disable iff (por)
    rst |=> io_rdata == 8'h00 && crystal_load_trim == `TRIM_RST)
    else $error("reset values wrong");
  a_rdata_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !io_rd |=> $stable(io_rdata))
    else $error("read data moved without read");
  a_trim_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_trim |=> {1'b0, crystal_load_trim} == ($past(io_wdata) & 8'h7f))
    else $error("trim not written");
  a_trim_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_trim |=> $stable(crystal_load_trim))
    else $error("trim changed unasked");
  a_trim_readback: assert property (@(posedge ref_clk) disable iff (rst)
    rd_trim |=> io_rdata == {1'b0, $past(crystal_load_trim)})
    else $error("trim read wrong");
  a_unmapped_read: assert property (@(posedge ref_clk) disable iff (rst)
    rd_none |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_restart_zero: assert property (@(posedge ref_clk) disable iff (rst)
    wr_rs ##2 rd_sub |=> io_rdata == 8'h00)
    else $error("subsecond not restarted");
  a_fraction_second_counter_range: assert property (@(posedge ref_clk) disable iff (rst)
    rd_sub |=> io_rdata <= `FRACTION_SECOND_COUNTER_MAX)
    else $error("subsecond out of range");
  a_freeze_readback: assert property (@(posedge ref_clk) disable iff (rst)
    wr_ctl ##1 !io_wr ##1 rd_ctl |=> (io_rdata[7:6] | ~$past(wfrz, 3)) == 2'b11)
    else $error("freeze bit not read as one");
  a_pulse_single: assert property (@(posedge ref_clk) disable iff (por)
    second_pulse |=> !second_pulse)
    else $error("second pulse too long");
endmodule

bind calendar_rtc calendar_rtc_chk u_chk (.ref_clk(ref_clk), .rst(rst),
  .por(por), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata),
  .crystal_load_trim(crystal_load_trim), .second_pulse(second_pulse));
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the calendar clock
`timescale 1ns/10ps
`default_nettype none
`include "rtc_defines.vh"

// ****************************************
// Bench top
// ****************************************
module tb;
  // Design stimulus and outputs
  logic ref_clk, rst, por, io_wr, io_rd, second_pulse;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata;
  logic [6:0] crystal_load_trim;
  // Notes of expected reads
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  string nm_q[$];
  logic [7:0] m, e;
  string n;
  // Counters and scratch
  int error_cnt = 0;
  int tests_run = 0;
  logic pend = 1'b0;
  logic [7:0] minv, trimv, minx;
  int cyc = 0;
  logic [3:0] i;
  // Power-on shadow, seconds up to rate low byte
  logic [7:0] pwr[0:10] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01,
    8'h00, 8'h00, 8'h04, 8'h00, 8'h00};

  // Crystal tick every clock keeps one second inside the run
  calendar_rtc #(.REF_HZ(`XTAL_HZ)) dut (.ref_clk(ref_clk), .rst(rst),
    .por(por),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .crystal_load_trim(crystal_load_trim),
    .second_pulse(second_pulse));

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and stop
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One byte write
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge ref_clk);
    io_wr = 1'b0;
  endtask

  // One byte read, expectation noted first; zero mask means no compare
  task automatic rd(logic [15:0] a, logic [7:0] ex, logic [7:0] mk,
                    string nm);
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    nm_q.push_back(nm);
    @(negedge ref_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge ref_clk);
    io_rd = 1'b0;
  endtask

  // Poll a control bit until it reads zero, bounded
  task automatic poll(int b, string nm);
    int k;
    for (k = 0; k < 300; k++) begin
      rd(`OFS_CTRL, 8'h00, 8'h00, nm);
      if (io_rdata[b] === 1'b0) break;
      repeat (100) @(negedge ref_clk);
    end
    check(nm, {7'h00, io_rdata[b]}, 8'h00);
  endtask

  // ****************************************
  // Monitor
  // ****************************************
  // Marks the cycle whose read data is valid
  always @(posedge ref_clk) begin
    pend <= io_rd && !rst;
  end

  // Clock edges since power-on release
  always @(posedge ref_clk) begin
    if (!por) cyc <= cyc + 1;
  end

  // Oldest note against the data returned
  always @(negedge ref_clk) begin
    if (pend && exp_q.size() > 0) begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      n = nm_q.pop_front();
      if (m !== 8'h00) check(n, io_rdata & m, e & m);
    end
  end

  // Cuts a hang short
  initial begin
    repeat (50000) @(posedge ref_clk);
    error_cnt++;
    end_of_test;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    por = 1'b1;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    void'($urandom(3));
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    por = 1'b0;
    // Power-on register values
    check("trim port", {1'b0, crystal_load_trim}, 8'h40);
    rd(`OFS_TRIM, 8'h40, 8'hff, "trim");
    rd(`OFS_CTRL, 8'h00, 8'hd0, "control");
    for (i = 4'h0; i < 4'hb; i++) begin
      rd(`OFS_SEC + {12'h000, i}, pwr[i], 8'hff, "shadow");
    end
    // Unmapped place
    wr(16'h2000, 8'h5a);
    rd(16'h2000, 8'h00, 8'hff, "unmapped");
    // Random trim value
    trimv = 8'($urandom) & 8'h7f;
    wr(`OFS_TRIM, trimv);
    rd(`OFS_TRIM, trimv, 8'hff, "trim");
    check("trim port", {1'b0, crystal_load_trim}, trimv);
    // Shadow refuses writes while unfrozen
    wr(`OFS_SEC, 8'h12);
    rd(`OFS_SEC, 8'h00, 8'hff, "sec");
    // Subsecond restart, read-only count
    wr(`OFS_RESTART, 8'h01);
    rd(`OFS_FRACTION_SECOND_COUNTER, 8'h00, 8'hff, "fraction_second_counter");
    wr(`OFS_FRACTION_SECOND_COUNTER, 8'h55);
    rd(`OFS_FRACTION_SECOND_COUNTER, 8'h00, 8'hff, "fraction_second_counter");
    // Writing one leaves the error flag clear
    wr(`OFS_CTRL, 8'h10);
    rd(`OFS_CTRL, 8'h00, 8'h10, "fail");
    // Write freeze, three words loaded, weekday out of range
    minv = 8'($urandom % 60);
    minx = (minv == 8'h3b) ? 8'h00 : minv + 8'h01;
    wr(`OFS_CTRL, 8'h80);
    rd(`OFS_CTRL, 8'h80, 8'h80, "wr freeze");
    wr(`OFS_SEC, 8'h3b);
    wr(`OFS_MIN, minv);
    wr(`OFS_DOW, 8'h00);
    rd(`OFS_SEC, 8'h3b, 8'hff, "sec");
    // Unfreeze midway between two internal ticks
    repeat (32) @(negedge ref_clk);
    wr(`OFS_CTRL, 8'h00);
    rd(`OFS_CTRL, 8'h80, 8'h80, "wr pending");
    poll(7, "load");
    // Reset clears shadow but not the chain
    @(negedge ref_clk);
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    rd(`OFS_MIN, 8'h00, 8'hff, "min shadow");
    // Read freeze, then wait for refresh
    wr(`OFS_CTRL, 8'h40);
    rd(`OFS_CTRL, 8'h40, 8'h40, "rd freeze");
    wr(`OFS_CTRL, 8'h00);
    rd(`OFS_CTRL, 8'h40, 8'h40, "rd stale");
    poll(6, "refresh");
    rd(`OFS_SEC, 8'h3b, 8'hff, "sec");
    rd(`OFS_MIN, minv, 8'hff, "min");
    rd(`OFS_HOUR, 8'h00, 8'hff, "hour");
    rd(`OFS_DOW, 8'h00, 8'hff, "dow");
    // First second boundary, bounded wait
    for (int w = 0; w < 40000 && second_pulse !== 1'b1; w++) begin
      @(negedge ref_clk);
    end
    check("second pulse", {31'h0, second_pulse}, 32'h1);
    check("second length", cyc, 32'(`XTAL_HZ) + 32'h1);
    @(negedge ref_clk);
    check("pulse width", {31'h0, second_pulse}, 32'h0);
    // Let a refresh take the advanced chain, then freeze
    repeat (100) @(negedge ref_clk);
    wr(`OFS_CTRL, 8'h50);
    rd(`OFS_SEC, 8'h00, 8'hff, "sec wrap");
    rd(`OFS_MIN, minx, 8'hff, "min carry");
    rd(`OFS_HOUR, {7'h00, minv == 8'h3b}, 8'hff, "hour carry");
    rd(`OFS_FRACTION_SECOND_COUNTER, 8'h00, 8'hff, "fraction_second_counter wrap");
    rd(`OFS_CTRL, 8'h50, 8'h50, "fail set");
    wr(`OFS_CTRL, 8'h00);
    rd(`OFS_CTRL, 8'h00, 8'h10, "fail clear");
    @(negedge ref_clk);
    end_of_test;
  end
endmodule
`default_nettype wire
